// *** rtl/uefc_pkg.sv ***
// package of shared constants and types for the endpoint configuration link
package uefc_pkg;
	// ----------------------------------------
	// sizes and counts
	// ----------------------------------------
	localparam int NUM_GEN_EP    = 5;
	localparam int NUM_REGIONS   = 6;
	localparam int PTR_W         = 12;
	localparam int SIZE_W        = 11;
	localparam int EPNUM_W       = 4;
	localparam int CFG_W         = 4;
	localparam int REGSEL_W      = 3;

	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [PTR_W-1:0]   RST_PTR      = 12'h000;
	localparam logic [SIZE_W-1:0]  RST_MAXPKT   = 11'h008;
	localparam logic [EPNUM_W-1:0] EPNUM_MIN    = 4'h1;
	localparam logic [EPNUM_W-1:0] EPNUM_MAX    = 4'hF;
	localparam logic [SIZE_W-1:0]  CTRL_MAX_HS  = 11'h040;

	// ----------------------------------------
	// general endpoint config field positions
	// ----------------------------------------
	localparam int CFG_DIR_BIT   = 0;
	localparam int CFG_TOG_BIT   = 1;
	localparam int CFG_ISO_BIT   = 2;
	localparam int CFG_VALID_BIT = 3;

	// ----------------------------------------
	// firmware command codes on the link
	// ----------------------------------------
	typedef enum logic [2:0] {
		UEFC_CMD_NONE   = 3'h0,
		UEFC_CMD_START  = 3'h1,
		UEFC_CMD_END    = 3'h2,
		UEFC_CMD_CLEAR  = 3'h3,
		UEFC_CMD_LINK   = 3'h4,
		UEFC_CMD_UNLINK = 3'h5,
		UEFC_CMD_CONFIG = 3'h6,
		UEFC_CMD_MAXPKT = 3'h7
	} uefc_cmd_t;

	// ----------------------------------------
	// host sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		UEFC_H_IDLE  = 5'h01,
		UEFC_H_START = 5'h02,
		UEFC_H_END   = 5'h04,
		UEFC_H_CLEAR = 5'h08,
		UEFC_H_LINK  = 5'h10
	} uefc_hstate_t;
endpackage

// *** rtl/uefc_if.sv ***
// interface joining the firmware end and the endpoint configuration end
`timescale 1ns/10ps
interface uefc_if;
	logic                          cmdValid;
	logic                          cmdReady;
	uefc_pkg::uefc_cmd_t           cmdCode;
	logic [uefc_pkg::REGSEL_W-1:0] cmdSel;
	logic [uefc_pkg::PTR_W-1:0]    cmdData;
	logic                          cmdErr;
	logic [uefc_pkg::NUM_REGIONS-1:0] linkState;

	modport dev (
		input  cmdValid,
		output cmdReady,
		input  cmdCode,
		input  cmdSel,
		input  cmdData,
		output cmdErr,
		output linkState
	);
	modport fw (
		output cmdValid,
		input  cmdReady,
		output cmdCode,
		output cmdSel,
		output cmdData,
		input  cmdErr,
		input  linkState
	);
endinterface

// *** rtl/uefc_device.sv ***
// endpoint configuration end: region pointers, clears, links and endpoint settings
// Notes on behaviour
// - one control plus five general endpoints
// - control endpoint direction chosen per stage
// - control data refused until region 0 linked
// - control max packet 8 to 64 bytes; code keeps any 11-bit value written
// - region spans at least the max packet; code does not check pointers against it
// - link bit attaches control endpoint to region
// - each general endpoint has own direction
// - endpoint number 0x1 to 0xF, matched on bus
// - general max packet sizes by speed rules; code keeps any 11-bit value written
// - toggle mode set per transfer kind
// - isochronous flag set for isochronous endpoints
// - no transactions until region linked
// - endpoint pairs only with its own region
// - firmware builds interfaces from endpoints
// - linked endpoint answers by fifo level
`timescale 1ns/10ps
module uefc_device #(
	parameter int NEP = uefc_pkg::NUM_GEN_EP
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	uefc_if.dev                                link,
	// usb side: token to look up and fifo levels of every region
	input  wire logic                          tokValid,
	input  wire logic [uefc_pkg::EPNUM_W-1:0]  tokEpNum,
	input  wire logic                          tokIsIn,
	input  wire logic [NEP:0]                  fifoHasPkt,
	input  wire logic [NEP:0]                  fifoHasRoom,
	input  wire logic                          ctrlDirIn,
	output logic                               tokHit,
	output logic [uefc_pkg::REGSEL_W-1:0]      tokRegion,
	output logic                               tokAck,
	output logic                               tokNak,
	output logic [NEP:0]                       regionClear,
	output logic [NEP:0][uefc_pkg::PTR_W-1:0]  regionStart,
	output logic [NEP:0][uefc_pkg::PTR_W-1:0]  regionEnd,
	output logic [NEP:0][uefc_pkg::SIZE_W-1:0] epMaxPkt,
	output logic [NEP-1:0]                     epIsIn,
	output logic [NEP-1:0]                     epToggleMode,
	output logic [NEP-1:0]                     epIso
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [NEP:0][uefc_pkg::PTR_W-1:0]  startPtr_ff;
	logic [NEP:0][uefc_pkg::PTR_W-1:0]  endPtr_ff;
	logic [NEP:0][uefc_pkg::SIZE_W-1:0] maxPkt_ff;
	logic [NEP:0]                       clear_ff;
	logic [NEP:0]                       cleared_ff;
	logic [NEP:0]                       link_ff;
	logic [NEP-1:0][uefc_pkg::CFG_W-1:0]   cfg_ff;
	logic [NEP-1:0][uefc_pkg::EPNUM_W-1:0] epNum_ff;
	logic                               err_ff;
	logic                               hit_ff;
	logic [uefc_pkg::REGSEL_W-1:0]      reg_ff;
	logic                               ack_ff;
	logic                               nak_ff;
	logic                               take;
	logic                               selOk;
	logic                               linkOk;
	logic [uefc_pkg::REGSEL_W-1:0]      s;
	logic                               lkHit;
	logic [uefc_pkg::REGSEL_W-1:0]      lkReg;
	logic                               lkRdy;

	// commands are taken in one cycle
	assign link.cmdReady = 1'b1;
	assign take          = link.cmdValid;
	assign s             = link.cmdSel;
	assign selOk         = (s <= uefc_pkg::REGSEL_W'(NEP));
	// link allowed only once the region has been cleared since its last start or end write
	assign linkOk        = selOk && cleared_ff[s];

	// ----------------------------------------
	// region pointers and clear pulse
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			startPtr_ff <= '0;
			endPtr_ff   <= '0;
			clear_ff    <= '0;
		end else begin
			clear_ff <= '0;
			if (take && selOk) begin
				if (link.cmdCode == uefc_pkg::UEFC_CMD_START)
					startPtr_ff[s] <= link.cmdData;
				if (link.cmdCode == uefc_pkg::UEFC_CMD_END)
					endPtr_ff[s] <= link.cmdData;
				if (link.cmdCode == uefc_pkg::UEFC_CMD_CLEAR)
					clear_ff[s] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// clear tracking and link bits
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cleared_ff <= '0;
			link_ff    <= '0;
		end else if (take && selOk) begin
			case (link.cmdCode)
				uefc_pkg::UEFC_CMD_START,
				uefc_pkg::UEFC_CMD_END: begin
					cleared_ff[s] <= 1'b0; // moved region must be cleared again
					link_ff[s]    <= 1'b0;
				end
				uefc_pkg::UEFC_CMD_CLEAR: cleared_ff[s] <= 1'b1;
				// region n is only ever joined to its own endpoint
				uefc_pkg::UEFC_CMD_LINK: if (linkOk) link_ff[s] <= 1'b1;
				uefc_pkg::UEFC_CMD_UNLINK: link_ff[s] <= 1'b0;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// endpoint settings
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			maxPkt_ff <= {(NEP+1){uefc_pkg::RST_MAXPKT}};
			cfg_ff    <= '0;
			epNum_ff  <= {NEP{uefc_pkg::EPNUM_MIN}};
		end else if (take && selOk) begin
			if (link.cmdCode == uefc_pkg::UEFC_CMD_MAXPKT)
				maxPkt_ff[s] <= link.cmdData[uefc_pkg::SIZE_W-1:0];
			// config word: number in 7:4, valid, iso, toggle, direction
			if (link.cmdCode == uefc_pkg::UEFC_CMD_CONFIG && s != 3'h0
				&& link.cmdData[7:4] >= uefc_pkg::EPNUM_MIN) begin
				cfg_ff[s-3'h1]   <= link.cmdData[uefc_pkg::CFG_W-1:0];
				epNum_ff[s-3'h1] <= link.cmdData[7:4];
			end
		end
	end

	// refused commands flag: bad select, early link, config to region 0 or with number 0
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			err_ff <= 1'b0;
		else if (take)
			err_ff <= !selOk
				|| (link.cmdCode == uefc_pkg::UEFC_CMD_LINK && !linkOk)
				|| (link.cmdCode == uefc_pkg::UEFC_CMD_CONFIG
					&& (s == 3'h0 || link.cmdData[7:4] < uefc_pkg::EPNUM_MIN));
	end

	// ----------------------------------------
	// token lookup and answer
	// ----------------------------------------
	// lookup of the token against region 0 and the joined endpoints
	always_comb begin
		lkHit = 1'b0;
		lkReg = '0;
		lkRdy = 1'b0;
		if (tokEpNum == 4'h0) begin
			// control uses region 0 either way, direction from firmware
			lkHit = link_ff[0];
			lkRdy = ctrlDirIn ? fifoHasPkt[0] : fifoHasRoom[0];
		end else begin
			for (int i = 0; i < NEP; i++) begin
				if (!lkHit && link_ff[i+1] && cfg_ff[i][uefc_pkg::CFG_VALID_BIT]
					&& epNum_ff[i] == tokEpNum
					&& cfg_ff[i][uefc_pkg::CFG_DIR_BIT] == tokIsIn) begin
					lkHit = 1'b1;
					lkReg = uefc_pkg::REGSEL_W'(i + 1);
					lkRdy = tokIsIn ? fifoHasPkt[i+1] : fifoHasRoom[i+1];
				end
			end
		end
	end

	// registered answer, one cycle after the token
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hit_ff <= 1'b0;
			reg_ff <= '0;
			ack_ff <= 1'b0;
			nak_ff <= 1'b0;
		end else begin
			hit_ff <= tokValid && lkHit;
			reg_ff <= lkReg;
			ack_ff <= tokValid && lkHit && lkRdy;
			nak_ff <= tokValid && lkHit && !lkRdy;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.cmdErr    = err_ff;
	assign link.linkState = link_ff;
	assign tokHit         = hit_ff;
	assign tokRegion      = reg_ff;
	assign tokAck         = ack_ff;
	assign tokNak         = nak_ff;
	assign regionClear    = clear_ff;
	assign regionStart    = startPtr_ff;
	assign regionEnd      = endPtr_ff;
	assign epMaxPkt       = maxPkt_ff;
	always_comb begin
		for (int i = 0; i < NEP; i++) begin
			epIsIn[i]       = cfg_ff[i][uefc_pkg::CFG_DIR_BIT];
			epToggleMode[i] = cfg_ff[i][uefc_pkg::CFG_TOG_BIT];
			epIso[i]        = cfg_ff[i][uefc_pkg::CFG_ISO_BIT];
		end
	end
endmodule

// *** rtl/uefc_firmware.sv ***
// firmware end: sets up a region and links it in the required order
`timescale 1ns/10ps
module uefc_firmware (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	uefc_if.fw                                 link,
	// user side: one region setup request, plain passthrough commands
	input  wire logic                          setupReq,
	input  wire logic [uefc_pkg::REGSEL_W-1:0] setupSel,
	input  wire logic [uefc_pkg::PTR_W-1:0]    setupStart,
	input  wire logic [uefc_pkg::PTR_W-1:0]    setupEnd,
	input  wire logic                          rawValid,
	input  wire uefc_pkg::uefc_cmd_t           rawCode,
	input  wire logic [uefc_pkg::REGSEL_W-1:0] rawSel,
	input  wire logic [uefc_pkg::PTR_W-1:0]    rawData,
	output logic                               setupBusy,
	output logic                               setupDone,
	output logic                               setupErr
);
	uefc_pkg::uefc_hstate_t          st_ff;
	uefc_pkg::uefc_hstate_t          nxt_st;
	logic [uefc_pkg::REGSEL_W-1:0]   sel_ff;
	logic [uefc_pkg::PTR_W-1:0]      start_ff;
	logic [uefc_pkg::PTR_W-1:0]      end_ff;
	logic                            done_ff;
	logic                            err_ff;

	// ----------------------------------------
	// setup sequence: start, end, clear, then link
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			uefc_pkg::UEFC_H_IDLE:  if (setupReq) nxt_st = uefc_pkg::UEFC_H_START;
			uefc_pkg::UEFC_H_START: if (link.cmdReady) nxt_st = uefc_pkg::UEFC_H_END;
			uefc_pkg::UEFC_H_END:   if (link.cmdReady) nxt_st = uefc_pkg::UEFC_H_CLEAR;
			uefc_pkg::UEFC_H_CLEAR: if (link.cmdReady) nxt_st = uefc_pkg::UEFC_H_LINK;
			uefc_pkg::UEFC_H_LINK:  if (link.cmdReady) nxt_st = uefc_pkg::UEFC_H_IDLE;
			default:                nxt_st = uefc_pkg::UEFC_H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			st_ff <= uefc_pkg::UEFC_H_IDLE;
		else
			st_ff <= nxt_st;
	end

	// latch request; the select names both endpoint and its own region
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sel_ff   <= '0;
			start_ff <= uefc_pkg::RST_PTR;
			end_ff   <= uefc_pkg::RST_PTR;
		end else if (st_ff == uefc_pkg::UEFC_H_IDLE && setupReq) begin
			sel_ff   <= setupSel;
			start_ff <= setupStart;
			end_ff   <= setupEnd;
		end
	end

	// done pulse and refusal seen at the link step
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else begin
			done_ff <= (st_ff == uefc_pkg::UEFC_H_LINK) && link.cmdReady;
			if (done_ff)
				err_ff <= link.cmdErr;
		end
	end

	// ----------------------------------------
	// drive the link; raw commands only while idle
	// ----------------------------------------
	always_comb begin
		link.cmdValid = 1'b0;
		link.cmdCode  = uefc_pkg::UEFC_CMD_NONE;
		link.cmdSel   = sel_ff;
		link.cmdData  = '0;
		case (st_ff)
			uefc_pkg::UEFC_H_START: begin
				link.cmdValid = 1'b1;
				link.cmdCode  = uefc_pkg::UEFC_CMD_START;
				link.cmdData  = start_ff;
			end
			uefc_pkg::UEFC_H_END: begin
				link.cmdValid = 1'b1;
				link.cmdCode  = uefc_pkg::UEFC_CMD_END;
				link.cmdData  = end_ff;
			end
			uefc_pkg::UEFC_H_CLEAR: begin
				link.cmdValid = 1'b1;
				link.cmdCode  = uefc_pkg::UEFC_CMD_CLEAR;
			end
			uefc_pkg::UEFC_H_LINK: begin
				link.cmdValid = 1'b1;
				link.cmdCode  = uefc_pkg::UEFC_CMD_LINK;
			end
			default: begin
				link.cmdValid = rawValid;
				link.cmdCode  = rawCode;
				link.cmdSel   = rawSel;
				link.cmdData  = rawData;
			end
		endcase
	end

	assign setupBusy = (st_ff != uefc_pkg::UEFC_H_IDLE);
	assign setupDone = done_ff;
	assign setupErr  = err_ff;
endmodule

// *** test/uefc_monitor.sv ***
// checker for the firmware to endpoint configuration link
`timescale 1ns/10ps
module uefc_monitor (
	input wire logic                                 core_clk,
	input wire logic                                 rst_n,
	input wire logic                                 cmdValid,
	input wire logic                                 cmdReady,
	input wire uefc_pkg::uefc_cmd_t                  cmdCode,
	input wire logic [uefc_pkg::REGSEL_W-1:0]        cmdSel,
	input wire logic [uefc_pkg::PTR_W-1:0]           cmdData,
	input wire logic                                 cmdErr,
	input wire logic [uefc_pkg::NUM_REGIONS-1:0]     linkState
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [5:0] clrd_ff;
	logic [2:0] selQ_ff;
	logic       okSel;
	logic       isLink;
	// a command aimed at an existing region
	assign okSel = cmdValid && (cmdSel <= 3'h5);
	assign isLink = okSel && (cmdCode == uefc_pkg::UEFC_CMD_LINK);
	// regions cleared since their last move
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			clrd_ff <= 6'h00;
		else if (okSel && (cmdCode inside {uefc_pkg::UEFC_CMD_START, uefc_pkg::UEFC_CMD_END}))
			clrd_ff[cmdSel] <= 1'b0;
		else if (okSel && cmdCode == uefc_pkg::UEFC_CMD_CLEAR)
			clrd_ff[cmdSel] <= 1'b1;
	end
	// select of the previous cycle, to find the answered bit
	always_ff @(posedge core_clk) begin
		selQ_ff <= cmdSel;
	end
	ready_high_a: assert property (cmdReady) else $error("link not ready");
	link_cause_a: assert property ((linkState & ~$past(linkState)) != 6'h00
		|-> $past(isLink && clrd_ff[cmdSel])) else $error("link rose without a link command");
	bad_sel_a: assert property (cmdValid && cmdSel > 3'h5 |=> cmdErr)
		else $error("bad select accepted");
	link_ok_a: assert property (isLink && clrd_ff[cmdSel] |=> linkState[selQ_ff] && !cmdErr)
		else $error("link of cleared region failed");
	link_refuse_a: assert property (isLink && !clrd_ff[cmdSel] |=> cmdErr && !linkState[selQ_ff])
		else $error("link of uncleared region taken");
	move_unlink_a: assert property (okSel && (cmdCode == uefc_pkg::UEFC_CMD_START ||
		cmdCode == uefc_pkg::UEFC_CMD_END) |=> !linkState[selQ_ff])
		else $error("moved region still linked");
	unlink_cmd_a: assert property (okSel && cmdCode == uefc_pkg::UEFC_CMD_UNLINK
		|=> !linkState[selQ_ff]) else $error("unlink ignored");
	cfg_refuse_a: assert property (cmdValid && cmdCode == uefc_pkg::UEFC_CMD_CONFIG &&
		(cmdSel == 3'h0 || cmdData[7:4] == 4'h0) |=> cmdErr) else $error("bad config taken");
	idle_hold_a: assert property (!cmdValid |=> $stable(linkState) && $stable(cmdErr))
		else $error("link state moved while idle");
	reset_zero_a: assert property (disable iff (1'b0) !rst_n |=> linkState == 6'h00)
		else $error("links not cleared by reset");
	cover property (isLink && clrd_ff[cmdSel]);
	cover property (isLink && !clrd_ff[cmdSel]);
	cover property (cmdValid && cmdCode == uefc_pkg::UEFC_CMD_CONFIG);
endmodule

// *** test/tb_top.sv ***
// self-checking bench joining the firmware end to the endpoint configuration end
`timescale 1ns/10ps
module tb_top;
	logic                core_clk = 1'b0, rst_n = 1'b0, setupReq = 1'b0, rawValid = 1'b0;
	logic                tokValid = 1'b0, tokIsIn = 1'b0, ctrlDirIn = 1'b0;
	logic [2:0]          setupSel = 3'h0, rawSel = 3'h0, tokRegion;
	logic [11:0]         setupStart = 12'h000, setupEnd = 12'h000, rawData = 12'h000;
	uefc_pkg::uefc_cmd_t rawCode = uefc_pkg::UEFC_CMD_NONE;
	logic [3:0]          tokEpNum = 4'h0;
	logic [5:0]          fifoHasPkt = 6'h00, fifoHasRoom = 6'h00, regionClear;
	logic                setupBusy, setupDone, setupErr, tokHit, tokAck, tokNak;
	logic [5:0][11:0]    regionStart, regionEnd;
	logic [5:0][10:0]    epMaxPkt;
	logic [4:0]          epIsIn, epToggleMode, epIso;
	int                  failures = 0, testsRun = 0;
	uefc_if lnk();
	uefc_firmware u_uefc_firmware (.core_clk, .rst_n, .link(lnk), .setupReq, .setupSel,
		.setupStart, .setupEnd, .rawValid, .rawCode, .rawSel, .rawData, .setupBusy,
		.setupDone, .setupErr);
	uefc_device #(.NEP(5)) u_uefc_device (.core_clk, .rst_n, .link(lnk), .tokValid,
		.tokEpNum, .tokIsIn, .fifoHasPkt, .fifoHasRoom, .ctrlDirIn, .tokHit, .tokRegion,
		.tokAck, .tokNak, .regionClear, .regionStart, .regionEnd, .epMaxPkt, .epIsIn,
		.epToggleMode, .epIso);
	uefc_monitor u_uefc_monitor (.core_clk, .rst_n, .cmdValid(lnk.cmdValid),
		.cmdReady(lnk.cmdReady), .cmdCode(lnk.cmdCode), .cmdSel(lnk.cmdSel),
		.cmdData(lnk.cmdData), .cmdErr(lnk.cmdErr), .linkState(lnk.linkState));
	// 25 MHz core clock
	always #20 core_clk = ~core_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic stop_test();
		if (failures == 0 && testsRun > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		testsRun++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one plain command on the link, held for one cycle; the caller checks the result
	task automatic raw(input uefc_pkg::uefc_cmd_t c, input logic [2:0] s, input logic [11:0] d);
		@(posedge core_clk);
		rawValid <= 1'b1;
		rawCode <= c;
		rawSel <= s;
		rawData <= d;
		@(posedge core_clk);
		rawValid <= 1'b0;
		#1;
	endtask
	// token lookup, region only compared on a hit
	task automatic tok(input logic [3:0] n, input logic i, input logic [5:0] e);
		@(posedge core_clk);
		tokValid <= 1'b1;
		tokEpNum <= n;
		tokIsIn <= i;
		@(posedge core_clk);
		tokValid <= 1'b0;
		#1;
		chk("token", e, {tokHit, tokAck, tokNak, tokHit ? tokRegion : 3'h0});
	endtask
	// full region setup through the firmware sequencer
	task automatic setup(input logic [2:0] s, input logic [11:0] st, input logic [11:0] en);
		logic saw;
		logic bz;
		saw = 1'b0;
		bz = 1'b0;
		@(posedge core_clk);
		setupReq <= 1'b1;
		setupSel <= s;
		setupStart <= st;
		setupEnd <= en;
		@(posedge core_clk);
		setupReq <= 1'b0;
		for (int k = 0; k < 20 && setupDone !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
			if (regionClear[s] === 1'b1) saw = 1'b1;
			if (setupBusy === 1'b1) bz = 1'b1;
		end
		if (setupDone !== 1'b1) begin
			failures++;
			stop_test();
		end
		@(posedge core_clk);
		#1;
		chk("setupErr", 16'h0000, setupErr);
		chk("cleared", 16'h0001, saw);
		chk("linked", 16'h0001, lnk.linkState[s]);
		chk("start", st, regionStart[s]);
		chk("end", en, regionEnd[s]);
		chk("busySeen", 16'h0001, bz);
		chk("busyEnd", 16'h0000, setupBusy);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ctrl();
		ctrlDirIn <= 1'b1;
		fifoHasPkt <= 6'h01;
		tok(4'h0, 1'b1, 6'h00);
		setup(3'h0, 12'h000, 12'h03F);
		tok(4'h0, 1'b1, 6'h30);
		ctrlDirIn <= 1'b0;
		tok(4'h0, 1'b1, 6'h28);
		raw(uefc_pkg::UEFC_CMD_MAXPKT, 3'h0, 12'h040);
		chk("ctrlMax", 16'h0040, epMaxPkt[0]);
	endtask
	task automatic t_general();
		logic [3:0] n;
		logic       d;
		fifoHasPkt <= 6'h22;
		fifoHasRoom <= 6'h04;
		for (int i = 1; i <= 5; i++) begin
			n = (i == 2) ? 4'h1 : 4'(i * 3);
			d = i[0];
			setup(3'(i), 12'(i * 256), 12'(i * 256 + 127));
			raw(uefc_pkg::UEFC_CMD_CONFIG, 3'(i), {4'h0, n, 1'b1, i == 5, i == 4, d});
			chk("cfgErr", 16'h0000, lnk.cmdErr);
			chk("cfg", {d, i == 4, i == 5}, {epIsIn[i-1], epToggleMode[i-1], epIso[i-1]});
			raw(uefc_pkg::UEFC_CMD_MAXPKT, 3'(i), 12'h200);
			chk("maxPkt", 16'h0200, epMaxPkt[i]);
			tok(n, d, {1'b1, d ? i == 1 || i == 5 : i == 2, d ? i == 3 : i == 4, 3'(i)});
			tok(n, !d, 6'h00);
		end
		chk("iso", 16'h0010, epIso);
		chk("toggle", 16'h0008, epToggleMode);
	endtask
	task automatic t_refuse();
		raw(uefc_pkg::UEFC_CMD_LINK, 3'h6, 12'h000);
		chk("selErr", 16'h0001, lnk.cmdErr);
		raw(uefc_pkg::UEFC_CMD_START, 3'h1, 12'h100);
		chk("moved", 16'h0000, lnk.linkState[1]);
		raw(uefc_pkg::UEFC_CMD_LINK, 3'h1, 12'h000);
		chk("linkErr", 16'h0001, lnk.cmdErr);
		chk("unlinked", 16'h0000, lnk.linkState[1]);
		tok(4'h3, 1'b1, 6'h00);
		raw(uefc_pkg::UEFC_CMD_CONFIG, 3'h0, 12'h0F9);
		chk("cfgSel0", 16'h0001, lnk.cmdErr);
		raw(uefc_pkg::UEFC_CMD_CONFIG, 3'h2, 12'h008);
		chk("cfgNum0", 16'h0001, lnk.cmdErr);
		tok(4'h1, 1'b0, 6'h32);
		raw(uefc_pkg::UEFC_CMD_UNLINK, 3'h2, 12'h000);
		tok(4'h1, 1'b0, 6'h00);
		raw(uefc_pkg::UEFC_CMD_CLEAR, 3'h1, 12'h000);
		raw(uefc_pkg::UEFC_CMD_LINK, 3'h1, 12'h000);
		chk("relink", 16'h0002, {lnk.linkState[1], lnk.cmdErr});
	endtask
	// reset, then each scenario in turn
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk("rstLink", 16'h0000, lnk.linkState);
		chk("rstMax", 16'h0008, epMaxPkt[1]);
		t_ctrl();
		t_general();
		t_refuse();
		stop_test();
	end
endmodule
